/* hw/tpc_pkg.sv */
// Package with register map, field layout and reset values of the timer counter core
package tpc_pkg;
    // Register byte addresses on the APB
    localparam logic [11:0] TPC_OFS_STATUS_CONTROL = 12'h000;
    localparam logic [11:0] TPC_OFS_COUNT_HIGH = 12'h004;
    localparam logic [11:0] TPC_OFS_COUNT_LOW = 12'h008;
    localparam logic [11:0] TPC_OFS_MODULO = 12'h00C;
    // Field positions inside timer_status_control
    localparam int TPC_OVF_FLAG_BIT = 7;
    localparam int TPC_OVF_IRQ_EN_BIT = 6;
    localparam int TPC_CENTER_PWM_BIT = 5;
    localparam int TPC_CLK_SRC_LSB = 3;
    localparam int TPC_PRESCALE_LSB = 0;
    // Clock source codes
    localparam logic [1:0] TPC_CLK_NONE = 2'h0;
    localparam logic [1:0] TPC_CLK_BUS = 2'h1;
    localparam logic [1:0] TPC_CLK_FIXED = 2'h2;
    localparam logic [1:0] TPC_CLK_EXT = 2'h3;
    // Values after reset, and the full count top used with a modulo of zero
    localparam logic [7:0] TPC_CONTROL_RST = 8'h00;
    localparam logic [15:0] TPC_COUNT_RST = 16'h0000;
    localparam logic [15:0] TPC_MODULO_RST = 16'h0000;
    localparam logic [15:0] TPC_FREE_TOP = 16'hFFFF;
    localparam logic [6:0] TPC_PRESCALE_RST = 7'h00;
    localparam logic [31:0] TPC_RDATA_RST = 32'h0000_0000;
endpackage

/* hw/tpc_timer_core.sv */
// Timer counter core: clock select, prescaler, counter, overflow flag, APB registers
//
// Decided for this implementation: the register offsets and register access over APB.
module tpc_timer_core
    import tpc_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extClk,
    input wire logic fixedClkTick,
    input wire logic loopActive,
    input wire logic debugHalt,
    output logic [15:0] count,
    output logic [15:0] moduloValue,
    output logic countDown,
    output logic centerPwm,
    output logic overflowIrq
);

    // Whole state of the block in one record
    typedef struct packed {
        logic ovfFlag;          // Overflow flag
        logic ovfIrqEn;         // Overflow interrupt enable
        logic centerSel;        // Up/down counting select
        logic [1:0] clkSrc;     // Clock source select
        logic [2:0] prescale;   // Prescale select
        logic [15:0] cnt;       // Counter
        logic [15:0] modulo;    // Modulo value
        logic down;             // Counting direction, high while counting down
        logic [6:0] presc;      // Prescaler divider chain
        logic clrArmed;         // Flag was read while set
        logic latched;          // Read buffer holds a snapshot
        logic pendHigh;         // Half that still has to be read
        logic [15:0] snap;      // Read buffer
        logic extSync1;         // First synchroniser stage
        logic extSync2;         // Second synchroniser stage
        logic extPrev;          // Edge detector history
        logic ready;            // APB answer
        logic slvErr;           // APB error answer
        logic [31:0] rdata;     // APB read data
        logic irq;              // Interrupt request
    } tpc_state_t;

    tpc_state_t cur;
    tpc_state_t nxt;

    // Bus decode and counter helpers, shared by logic and checks
    logic access;               // Access phase
    logic done;                 // Completing edge of a transfer
    logic wrCtl;                // Completing write to control
    logic wrCnt;                // Completing write to either count byte
    logic rdCnt;                // Completing read of either count byte
    logic srcTick;              // Selected source edge
    logic cntTick;              // Counter step after prescaler
    logic ovfEvent;             // Counter returned to zero
    logic [15:0] top;           // Effective end of count

    // Mask of prescaler bits that must be all ones for a step
    function automatic logic [6:0] preMask(input logic [2:0] sel);
        logic [7:0] m;
        m = (8'h01 << sel) - 8'h01;
        return m[6:0];
    endfunction

    // One byte of the count, taken from the buffer while it is loaded
    function automatic logic [7:0] cntByte(input tpc_state_t s, input logic high);
        logic [15:0] v;
        v = s.latched ? s.snap : s.cnt;
        return high ? v[15:8] : v[7:0];
    endfunction

    assign access = psel & penable;
    assign done = access & cur.ready;
    assign wrCtl = done & pwrite & (paddr == TPC_OFS_STATUS_CONTROL);
    assign wrCnt = done & pwrite & ((paddr == TPC_OFS_COUNT_HIGH) | (paddr == TPC_OFS_COUNT_LOW));
    assign rdCnt = done & ~pwrite & ((paddr == TPC_OFS_COUNT_HIGH) | (paddr == TPC_OFS_COUNT_LOW));
    // A modulo of zero lets the counter run its full range
    assign top = (cur.modulo == TPC_MODULO_RST) ? TPC_FREE_TOP : cur.modulo;

    // Source selection; prescaler sits after it
    always_comb begin
        unique case (cur.clkSrc)
            TPC_CLK_NONE: srcTick = 1'b0;
            TPC_CLK_BUS: srcTick = 1'b1;
            // Without an active loop the fixed clock is the bus clock
            TPC_CLK_FIXED: srcTick = loopActive ? fixedClkTick : 1'b1;
            TPC_CLK_EXT: srcTick = cur.extSync2 & ~cur.extPrev;
        endcase
    end

    // Step when the low prescaler bits are all ones; uses the live field, so a new
    // value acts on the very next cycle
    assign cntTick = srcTick & ~debugHalt & ((cur.presc & preMask(cur.prescale)) == preMask(cur.prescale));

    // Next state of the whole block
    always_comb begin
        nxt = cur;
        ovfEvent = 1'b0;
        // External pin: two stages, then edge history reads the second only
        nxt.extSync1 = extClk;
        nxt.extSync2 = cur.extSync1;
        nxt.extPrev = cur.extSync2;
        // Prescaler advances only on source edges
        if (srcTick && !debugHalt) begin
            nxt.presc = cur.presc + 7'h01;
        end
        // Counter step
        if (cntTick) begin
            if (!cur.centerSel) begin
                nxt.down = 1'b0;
                if (cur.cnt >= top) begin
                    nxt.cnt = TPC_COUNT_RST;
                    ovfEvent = 1'b1;
                end else begin
                    nxt.cnt = cur.cnt + 16'h0001;
                end
            end else if (!cur.down) begin
                // Turn round at the modulo value
                if (cur.cnt >= top) begin
                    nxt.down = 1'b1;
                    nxt.cnt = cur.cnt - 16'h0001;
                end else begin
                    nxt.cnt = cur.cnt + 16'h0001;
                end
            end else begin
                // Turn round at zero; reaching zero from one is the overflow
                if (cur.cnt <= 16'h0001) begin
                    nxt.cnt = TPC_COUNT_RST;
                    nxt.down = 1'b0;
                    ovfEvent = (cur.cnt == 16'h0001);
                end else begin
                    nxt.cnt = cur.cnt - 16'h0001;
                end
            end
        end
        // APB answer one cycle into the access phase
        nxt.ready = access & ~cur.ready;
        nxt.slvErr = 1'b0;
        if (access && !cur.ready) begin
            nxt.rdata = TPC_RDATA_RST;
            unique case (paddr)
                TPC_OFS_STATUS_CONTROL: begin
                    nxt.rdata[7:0] = {cur.ovfFlag, cur.ovfIrqEn, cur.centerSel,
                                      cur.clkSrc, cur.prescale};
                end
                TPC_OFS_COUNT_HIGH: nxt.rdata[7:0] = cntByte(cur, 1'b1);
                TPC_OFS_COUNT_LOW: nxt.rdata[7:0] = cntByte(cur, 1'b0);
                TPC_OFS_MODULO: nxt.rdata[15:0] = cur.modulo;
                // Unmapped addresses answer with an error and zero data
                default: nxt.slvErr = 1'b1;
            endcase
        end
        // Reading control arms the clear only when the returned byte showed the flag;
        // a flag that rose after the data was formed stays unseen and must not clear
        if (done && !pwrite && paddr == TPC_OFS_STATUS_CONTROL
                && cur.rdata[TPC_OVF_FLAG_BIT]) begin
            nxt.clrArmed = 1'b1;
        end
        // While the buffer is free it follows the count, and stops at the edge that
        // completes a count read; the buffer then holds the very value that formed
        // the returned byte, so a count moving between the two phases cannot split
        // the pair
        if (!cur.latched && !rdCnt) begin
            nxt.snap = cur.cnt;
        end
        // Count byte read outside halt: first read locks the buffer, read of the other half frees
        if (rdCnt && !debugHalt) begin
            if (!cur.latched) begin
                nxt.latched = 1'b1;
                nxt.pendHigh = (paddr == TPC_OFS_COUNT_LOW);
            end else if ((paddr == TPC_OFS_COUNT_HIGH) == cur.pendHigh) begin
                nxt.latched = 1'b0;
            end
        end
        // Control write; a zero in the flag bit clears only when armed
        if (wrCtl) begin
            nxt.ovfIrqEn = pwdata[TPC_OVF_IRQ_EN_BIT];
            nxt.centerSel = pwdata[TPC_CENTER_PWM_BIT];
            nxt.clkSrc = pwdata[TPC_CLK_SRC_LSB +: 2];
            nxt.prescale = pwdata[TPC_PRESCALE_LSB +: 3];
            if (!pwdata[TPC_OVF_FLAG_BIT] && cur.clrArmed) begin
                nxt.ovfFlag = 1'b0;
            end
            nxt.clrArmed = 1'b0;
            nxt.latched = 1'b0;
        end
        // Any data written to a count byte clears the count
        if (wrCnt) begin
            nxt.cnt = TPC_COUNT_RST;
            nxt.down = 1'b0;
            nxt.presc = TPC_PRESCALE_RST;
            nxt.latched = 1'b0;
            ovfEvent = 1'b0;
        end
        // Modulo is written directly; buffering lives outside this core
        if (done && pwrite && paddr == TPC_OFS_MODULO) begin
            nxt.modulo = pwdata[15:0];
        end
        // Overflow wins over a clear in the same cycle and disarms it
        if (ovfEvent) begin
            nxt.ovfFlag = 1'b1;
            nxt.clrArmed = 1'b0;
        end
        nxt.irq = nxt.ovfFlag & nxt.ovfIrqEn;
    end

    // State register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    // Outputs straight from the state
    assign prdata = cur.rdata;
    assign pready = cur.ready;
    assign pslverr = cur.slvErr;
    assign count = cur.cnt;
    assign moduloValue = cur.modulo;
    assign countDown = cur.down;
    assign centerPwm = cur.centerSel;
    assign overflowIrq = cur.irq;

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    property p_flag_at_zero;
        $rose(cur.ovfFlag) |-> cur.cnt == TPC_COUNT_RST;
    endproperty
    a_flag_at_zero: assert property (p_flag_at_zero) else $error("flag set off zero");

    property p_clear_needs_sequence;
        $fell(cur.ovfFlag) |-> $past(wrCtl) && !$past(pwdata[7]) && $past(cur.clrArmed);
    endproperty
    a_clear_needs_sequence: assert property (p_clear_needs_sequence) else $error("bad clear");

    property p_overflow_sets;
        ovfEvent |=> cur.ovfFlag && !cur.clrArmed;
    endproperty
    a_overflow_sets: assert property (p_overflow_sets) else $error("overflow lost");

    property p_write_one_keeps;
        wrCtl && pwdata[7] && cur.ovfFlag |=> cur.ovfFlag;
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps) else $error("flag lost");

    property p_irq_follows;
        overflowIrq == (cur.ovfFlag && cur.ovfIrqEn);
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch");

    property p_up_only;
        !cur.centerSel && cntTick |=> !countDown;
    endproperty
    a_up_only: assert property (p_up_only) else $error("down in up mode");

    property p_stopped;
        cur.clkSrc == TPC_CLK_NONE && !wrCnt |=> $stable(cur.cnt);
    endproperty
    a_stopped: assert property (p_stopped) else $error("count moved");

    property p_div128;
        cntTick && cur.prescale == 3'h7 |-> cur.presc == 7'h7F;
    endproperty
    a_div128: assert property (p_div128) else $error("prescale wrong");

    property p_cnt_write;
        wrCnt |=> cur.cnt == TPC_COUNT_RST && !cur.latched;
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("count not cleared");

    property p_halt_count;
        debugHalt && !wrCnt |=> $stable(cur.cnt);
    endproperty
    a_halt_count: assert property (p_halt_count) else $error("count ran in halt");

    property p_halt_latch;
        debugHalt && !wrCtl && !wrCnt |=> $stable(cur.latched);
    endproperty
    a_halt_latch: assert property (p_halt_latch) else $error("latch moved in halt");

    property p_snap;
        rdCnt && !cur.latched && !debugHalt |=> cur.latched && cur.snap == $past(cur.cnt, 2);
    endproperty
    a_snap: assert property (p_snap) else $error("no snapshot");

    // Any control write frees the read buffer, in halt as well
    property p_rearm_ctl;
        wrCtl |=> !cur.latched;
    endproperty
    a_rearm_ctl: assert property (p_rearm_ctl) else $error("buffer kept");

    // Arming needs a read that actually returned the flag set
    property p_arm_seen;
        $rose(cur.clrArmed) |-> $past(cur.rdata[TPC_OVF_FLAG_BIT]);
    endproperty
    a_arm_seen: assert property (p_arm_seen) else $error("armed unseen");

    // A zero written without arming leaves a set flag alone
    property p_clear_only_armed;
        wrCtl && !cur.clrArmed && cur.ovfFlag |=> cur.ovfFlag;
    endproperty
    a_clear_only_armed: assert property (p_clear_only_armed) else $error("flag cleared");

    // Up/down mode turns downward at the top
    property p_down_turn;
        cur.centerSel && cntTick && !cur.down && cur.cnt >= top && !wrCnt |=> countDown;
    endproperty
    a_down_turn: assert property (p_down_turn) else $error("no turn");

    // Without an active loop the fixed source ticks like the bus
    property p_fixed_as_bus;
        cur.clkSrc == TPC_CLK_FIXED && !loopActive |-> srcTick;
    endproperty
    a_fixed_as_bus: assert property (p_fixed_as_bus) else $error("fixed source idle");

    // A written prescale code is in place for the very next cycle
    property p_prescale_next;
        wrCtl |=> cur.prescale == $past(pwdata[TPC_PRESCALE_LSB +: 3]);
    endproperty
    a_prescale_next: assert property (p_prescale_next) else $error("prescale late");

    // Modulo zero: the count climbs past any value up to the full top
    property p_free_run;
        !cur.centerSel && cntTick && cur.modulo == TPC_MODULO_RST && cur.cnt != TPC_FREE_TOP
            && !wrCnt |=> cur.cnt == $past(cur.cnt) + 16'h0001;
    endproperty
    a_free_run: assert property (p_free_run) else $error("free run broken");

    // Halt freezes the prescaler as well, so no step is half done on exit
    property p_halt_presc;
        debugHalt && !wrCnt |=> $stable(cur.presc);
    endproperty
    a_halt_presc: assert property (p_halt_presc) else $error("prescaler ran in halt");

    // Bus answer lasts one cycle; an error answer carries zero data
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");

    property p_err_zero;
        pslverr |-> pready && prdata == TPC_RDATA_RST;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error answer wrong");

    c_overflow: cover property (ovfEvent);
    c_flag_clear: cover property ($fell(cur.ovfFlag));
    c_turn_down: cover property ($rose(countDown));
    c_coherent: cover property (rdCnt && cur.latched);
    c_halt_read: cover property (debugHalt && rdCnt);

endmodule

/* tb/timer_counter_core_control_test.sv */
// Self-checking bench for the timer counter core, driven over APB
module timer_counter_core_control_test import tpc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // Short aliases of the register addresses
    localparam logic [11:0] AC = TPC_OFS_STATUS_CONTROL;
    localparam logic [11:0] AH = TPC_OFS_COUNT_HIGH;
    localparam logic [11:0] AL = TPC_OFS_COUNT_LOW;
    localparam logic [11:0] AM = TPC_OFS_MODULO;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic extClk = 1'b0;
    // Fixed tick and loop flag start low: fixed select must then act as bus
    logic fixedClkTick = 1'b0;
    logic loopActive = 1'b0;
    logic debugHalt = 1'b0;
    logic [15:0] count;
    logic [15:0] moduloValue;
    logic countDown;
    logic centerPwm;
    logic overflowIrq;
    int failures = 0;
    int testsRun = 0;
    logic [32:0] expQ[$]; // Expected {pslverr, prdata} of each read
    logic [31:0] seed = 32'hAAEFE2D3;

    tpc_timer_core dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extClk(extClk),
        .fixedClkTick(fixedClkTick), .loopActive(loopActive), .debugHalt(debugHalt),
        .count(count), .moduloValue(moduloValue), .countDown(countDown),
        .centerPwm(centerPwm), .overflowIrq(overflowIrq));

    // 125 MHz bus clock
    initial begin
        forever #4 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        testsRun++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One APB transfer; the request holds until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle cycle so no strobe is driven twice in one time step
        @(posedge mclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        expQ.push_back({1'b0, 24'h0, e});
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic ctl(input logic [7:0] d);
        wr(AC, {24'h0, d});
    endtask

    // Counter clear with random data to a random byte
    task automatic clr();
        seed = lfsr(seed);
        wr(seed[2] ? AH : AL, seed);
    endtask

    // External clock pulses, well under a quarter of the bus rate
    task automatic pulse(input int n);
        repeat (n) begin
            extClk <= 1'b1;
            repeat (4) @(posedge mclk);
            extClk <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        // Let the synchroniser drain
        repeat (6) @(posedge mclk);
    endtask

    task automatic waitIrq();
        int n = 0;
        while (overflowIrq !== 1'b1 && n < 64) begin
            @(posedge mclk);
            n++;
        end
        check("overflowIrq", 33'(overflowIrq), 33'h1);
        if (overflowIrq !== 1'b1) begin
            end_sim();
        end
    endtask

    // Monitor: each completed read is compared with the oldest note
    always @(posedge mclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (expQ.size() == 0)
                check("unnoted read", 33'h0, 33'h1);
            else
                check("read", {pslverr, prdata}, expQ.pop_front());
        end
    end

    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rd(AC, 8'h00);
        rd(AH, 8'h00);
        expQ.push_back({1'b1, 32'h0});
        xfer(1'b0, 12'h010, 32'h0);
        $display("test reset done");
        // Every prescale code on the external source
        wr(AM, 32'h0);
        for (int p = 0; p < 8; p++) begin
            ctl(8'h18 | 8'(p));
            clr();
            pulse(3 << p);
            rd(AL, 8'h03);
            rd(AH, 8'h00);
        end
        // Slow bus count, then prescale 0 must step from the next cycle on
        ctl(8'h0F);
        clr();
        ctl(8'h08);
        rd(AL, 8'h02);
        ctl(8'h00);
        clr();
        pulse(5);
        rd(AL, 8'h00);
        $display("test prescale done");
        // Coherent two-byte reads, then a debug halt in mid-read
        ctl(8'h18);
        clr();
        pulse(300);
        rd(AH, 8'h01);
        pulse(300);
        rd(AH, 8'h01);
        rd(AL, 8'h2C);
        rd(AL, 8'h58);
        debugHalt <= 1'b1;
        pulse(20);
        check("count", 33'(count), 33'h258);
        rd(AH, 8'h02);
        debugHalt <= 1'b0;
        pulse(20);
        rd(AL, 8'h58);
        rd(AH, 8'h02);
        rd(AL, 8'h6C);
        // Control write in halt frees the buffer: frozen count is read
        pulse(4);
        debugHalt <= 1'b1;
        ctl(8'h18);
        rd(AL, 8'h70);
        debugHalt <= 1'b0;
        ctl(8'h18);
        pulse(1);
        rd(AL, 8'h71);
        rd(AH, 8'h02);
        $display("test coherency done");
        // Overflow flag set, clear sequence, restart and write of one
        wr(AM, 32'h4);
        rd(AM, 8'h04);
        check("moduloValue", 33'(moduloValue), 33'h4);
        ctl(8'h58);
        clr();
        pulse(4);
        rd(AC, 8'h58);
        pulse(1);
        check("overflowIrq", 33'(overflowIrq), 33'h1);
        rd(AC, 8'hD8);
        rd(AL, 8'h00);
        pulse(5);
        ctl(8'h58);
        rd(AC, 8'hD8);
        ctl(8'h18);
        rd(AC, 8'h18);
        check("overflowIrq", 33'(overflowIrq), 33'h0);
        pulse(5);
        ctl(8'h58);
        rd(AC, 8'hD8);
        ctl(8'hD8);
        rd(AC, 8'hD8);
        $display("test overflow done");
        // Up/down counting; this control write also clears the flag
        wr(AM, 32'h3);
        ctl(8'h38);
        clr();
        check("centerPwm", 33'(centerPwm), 33'h1);
        pulse(4);
        rd(AL, 8'h02);
        check("countDown", 33'(countDown), 33'h1);
        rd(AH, 8'h00);
        pulse(2);
        rd(AC, 8'hB8);
        ctl(8'h00);
        $display("test updown done");
        // Bus and fixed sources run the counter at bus rate
        for (int s = 1; s < 3; s++) begin
            ctl(8'h40 | 8'(s << 3));
            waitIrq();
            ctl(8'h40);
            rd(AC, 8'hC0);
            ctl(8'h00);
            rd(AC, 8'h00);
        end
        // Fixed source with an active loop steps only on its ticks
        loopActive <= 1'b1;
        ctl(8'h10);
        clr();
        repeat (5) begin
            fixedClkTick <= 1'b1;
            @(posedge mclk);
            fixedClkTick <= 1'b0;
            repeat (3) @(posedge mclk);
        end
        rd(AL, 8'h01);
        $display("test sources done");
        end_sim();
    end
endmodule
